// [verilog/dsa_defs.svh]
// Offsets, field positions, reset values and constants of the accumulator post-adder block.
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH
`define DSA_CFG_OFS      8'h00
`define DSA_STAT_OFS     8'h04
`define DSA_W13_OFS      8'h08
`define DSA_ACCA_OFS     8'h0c
`define DSA_ACCB_OFS     8'h10
`define DSA_GUARD_OFS    8'h14
`define DSA_CFG_SAT_A    0
`define DSA_CFG_SAT_B    1
`define DSA_CFG_WIDTH    2
`define DSA_CFG_DW_SAT   3
`define DSA_CFG_RND      4
`define DSA_CFG_CATASTROPHIC_OVERFLOW_TRAP_ENABLE    5
`define DSA_CFG_RST      6'h00
`define DSA_ST_OV_A      0
`define DSA_ST_OV_B      1
`define DSA_ST_SAT_A     2
`define DSA_ST_SAT_B     3
`define DSA_ST_OV_ANY    4
`define DSA_ST_SAT_ANY   5
`define DSA_W13_RST      16'h0000
`define DSA_MAX39_POS    40'h7fffffffff
`define DSA_MAX39_NEG    40'h8000000000
`define DSA_MAX31_POS    40'h007fffffff
`define DSA_MAX31_NEG    40'hff80000000
`define DSA_DW_POS_LIM   24'h007fff
`define DSA_DW_NEG_LIM   24'hff8000
`define DSA_DW_POS_MAX   16'h7fff
`define DSA_DW_NEG_MAX   16'h8000
`define DSA_RND_TIE      16'h8000
`define DSA_W13_STEP     16'h0002
`define DSA_SH_MAX_R     6'sd15
`define DSA_SH_MAX_L     -6'sd16
`define DSA_RESP_OKAY    2'b00
`define DSA_RESP_SLVERR  2'b10
`endif

// [verilog/dsa_pkg.sv]
// Types shared by the accumulator post-adder block.
package dsa_pkg;
  typedef enum logic [2:0] {
    sk_none, sk_store_trunc, sk_store_round, sk_mac_wb,
    sk_mpy, sk_mpy_neg, sk_sqdiff, sk_acc_sqdiff
  } dsa_store_kind_type;
  typedef enum logic [1:0] {
    ss_acc_a, ss_acc_b, ss_xbus
  } dsa_shift_src_type;
endpackage : dsa_pkg

// [verilog/dsa_accum_post.sv]
// Saturation, rounding, write saturation and barrel shifter behind an AXI4-Lite port.
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module dsa_accum_post (
  input  wire logic         aclk,          // Core clock.
  input  wire logic         aresetn,       // Synchronous reset, low.
  input  wire logic [7:0]   s_axi_awaddr,  // Write address.
  input  wire logic         s_axi_awvalid, // Write address valid.
  output logic              s_axi_awready, // Write address ready.
  input  wire logic [31:0]  s_axi_wdata,   // Write data.
  input  wire logic [3:0]   s_axi_wstrb,   // Write strobes.
  input  wire logic         s_axi_wvalid,  // Write data valid.
  output logic              s_axi_wready,  // Write data ready.
  output logic [1:0]        s_axi_bresp,   // Write response.
  output logic              s_axi_bvalid,  // Write response valid.
  input  wire logic         s_axi_bready,  // Write response ready.
  input  wire logic [7:0]   s_axi_araddr,  // Read address.
  input  wire logic         s_axi_arvalid, // Read address valid.
  output logic              s_axi_arready, // Read address ready.
  output logic [31:0]       s_axi_rdata,   // Read data.
  output logic [1:0]        s_axi_rresp,   // Read response.
  output logic              s_axi_rvalid,  // Read data valid.
  input  wire logic         s_axi_rready,  // Read data ready.
  input  wire logic         add_valid,     // Adder pass this cycle.
  input  wire logic         add_target_b,  // Pass targets B.
  input  wire logic [39:0]  add_result,    // Raw adder sum.
  input  wire logic         add_ovf39,     // Adder bit 39 overflow.
  input  wire logic [2:0]   st_kind,       // Store kind.
  input  wire logic         st_acc_b,      // Store source is B.
  input  wire logic         st_indirect,   // Write-back via pointer.
  input  wire logic [15:0]  st_addr,       // Store address.
  input  wire logic         sh_valid,      // Shift request.
  input  wire logic [1:0]   sh_src,        // Shift source.
  input  wire logic signed [5:0] sh_amount, // Signed shift amount.
  input  wire logic         sh_arith,      // Arithmetic right shift.
  input  wire logic [15:0]  xbus_in,       // X bus operand.
  output logic              xbus_wr_valid, // Data write strobe.
  output logic [15:0]       xbus_wr_addr,  // Data write address.
  output logic [15:0]       xbus_wr_data,  // Data write value.
  output logic [39:0]       acc_a,         // Accumulator A.
  output logic [39:0]       acc_b,         // Accumulator B.
  output logic [39:0]       sh_result,     // Shifter 40-bit result.
  output logic [15:0]       sh_word,       // Shifter 16-bit result.
  output logic              trap_request,  // Arithmetic warning trap.
  output logic [5:0]        status_bits    // Status flags.
);

  logic [5:0]  cfg_r;
  logic [15:0] w13_r;
  logic [39:0] acc_a_r;
  logic [39:0] acc_b_r;
  logic        ov_a_r;
  logic        ov_b_r;
  logic        sat_a_r;
  logic        sat_b_r;
  logic        trap_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        xwr_valid_r;
  logic [15:0] xwr_addr_r;
  logic [15:0] xwr_data_r;
  logic [39:0] sh_res_r;
  logic [15:0] sh_word_r;

  // Guard bits disagree when bits 39..32 are not all equal.
  function automatic logic guard_bad(input logic [39:0] v);
    guard_bad = (v[39:31] != {9{v[39]}}) ? (v[39:32] != {8{v[39]}}) : 1'b0;
  endfunction : guard_bad

  // Bits 39..31 are not all equal to the sign bit.
  function automatic logic bit31_bad(input logic [39:0] v);
    bit31_bad = (v[39:31] != {9{v[39]}});
  endfunction : bit31_bad

  // Register decode, shared by the read and write paths.
  function automatic logic known_reg(input logic [7:0] a);
    known_reg = (a == `DSA_CFG_OFS) || (a == `DSA_STAT_OFS)
             || (a == `DSA_W13_OFS) || (a == `DSA_ACCA_OFS)
             || (a == `DSA_ACCB_OFS) || (a == `DSA_GUARD_OFS);
  endfunction : known_reg

  // Adder pass: saturation decision for the targeted accumulator.
  logic        sat_en;
  logic        wide_mode;
  logic        true_neg;
  logic [39:0] acc_nxt;
  logic        sat_hit;
  logic        ov_nxt;
  always_comb
  begin
    sat_en    = add_target_b ? cfg_r[`DSA_CFG_SAT_B] : cfg_r[`DSA_CFG_SAT_A];
    wide_mode = cfg_r[`DSA_CFG_WIDTH];
    // A bit 39 overflow flipped the sign, so the true sign is inverted.
    true_neg  = add_ovf39 ? ~add_result[39] : add_result[39];
    acc_nxt   = add_result;
    sat_hit   = 1'b0;
    ov_nxt    = guard_bad(add_result);
    if (sat_en && wide_mode)
    begin
      if (add_ovf39)
      begin
        acc_nxt = true_neg ? `DSA_MAX39_NEG : `DSA_MAX39_POS;
        sat_hit = 1'b1;
      end
    end
    else if (sat_en)
    begin
      ov_nxt = 1'b0;
      if (add_ovf39 || bit31_bad(add_result))
      begin
        acc_nxt = true_neg ? `DSA_MAX31_NEG : `DSA_MAX31_POS;
        sat_hit = 1'b1;
      end
    end
    else
    begin
      // Catastrophic mode keeps the wrapped sum.
      sat_hit = add_ovf39;
    end
  end

  // Accumulators hold the saturated or wrapped sum.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_a_r <= '0;
      acc_b_r <= '0;
    end
    else if (add_valid && add_target_b)
      acc_b_r <= acc_nxt;
    else if (add_valid)
      acc_a_r <= acc_nxt;
  end

  // Guard flags follow each pass; saturation flags are sticky.
  logic wr_fire;
  logic clr_a;
  logic clr_b;
  assign wr_fire = ~awready_r & ~wready_r & ~bvalid_r;
  assign clr_a = wr_fire && awaddr_r == `DSA_STAT_OFS && wstrb_r[0]
                 && wdata_r[`DSA_ST_SAT_A];
  assign clr_b = wr_fire && awaddr_r == `DSA_STAT_OFS && wstrb_r[0]
                 && wdata_r[`DSA_ST_SAT_B];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ov_a_r  <= 1'b0;
      ov_b_r  <= 1'b0;
      sat_a_r <= 1'b0;
      sat_b_r <= 1'b0;
    end
    else
    begin
      if (add_valid && !add_target_b)
        ov_a_r <= ov_nxt;
      if (add_valid && add_target_b)
        ov_b_r <= ov_nxt;
      // A new saturation wins over a clear in the same cycle.
      if (add_valid && !add_target_b && sat_hit)
        sat_a_r <= 1'b1;
      else if (clr_a)
        sat_a_r <= 1'b0;
      if (add_valid && add_target_b && sat_hit)
        sat_b_r <= 1'b1;
      else if (clr_b)
        sat_b_r <= 1'b0;
    end
  end

  // Trap request is a level while a flag of an unsaturated accumulator stands.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trap_r <= 1'b0;
    else
      trap_r <= cfg_r[`DSA_CFG_CATASTROPHIC_OVERFLOW_TRAP_ENABLE]
                & ((sat_a_r & ~cfg_r[`DSA_CFG_SAT_A])
                |  (sat_b_r & ~cfg_r[`DSA_CFG_SAT_B]));
  end

  // Round stage feeding the write saturation stage.
  dsa_pkg::dsa_store_kind_type kind;
  logic [39:0] src;
  logic        do_round;
  logic        inc;
  logic [23:0] rnd24;
  logic [15:0] wr_data;
  logic        wb_ok;
  logic        st_ok;
  always_comb
  begin
    kind  = dsa_pkg::dsa_store_kind_type'(st_kind);
    src   = st_acc_b ? acc_b_r : acc_a_r;
    // Only the MAC write-back store kind (sk_mac_wb) may write back.
    wb_ok = (kind == dsa_pkg::sk_mac_wb);
    st_ok = (kind == dsa_pkg::sk_store_trunc) || (kind == dsa_pkg::sk_store_round);
    do_round = (kind == dsa_pkg::sk_store_round) || wb_ok;
    if (cfg_r[`DSA_CFG_RND])
      inc = src[15] & ((src[15:0] != `DSA_RND_TIE) | src[16]);
    else
      inc = src[15];
    // Truncation simply drops the low word.
    rnd24 = src[39:16] + {23'h0, do_round & inc};
    wr_data = rnd24[15:0];
    if (cfg_r[`DSA_CFG_DW_SAT])
    begin
      // A negative word that rounds up to zero is not below the limit.
      if (!src[39] && rnd24 > `DSA_DW_POS_LIM)
        wr_data = `DSA_DW_POS_MAX;
      else if (src[39] && rnd24[23] && rnd24 < `DSA_DW_NEG_LIM)
        wr_data = `DSA_DW_NEG_MAX;
    end
  end

  // Data write leaves at the edge that ends the store cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xwr_valid_r <= 1'b0;
      xwr_addr_r  <= '0;
      xwr_data_r  <= '0;
    end
    else
    begin
      xwr_valid_r <= st_ok | (wb_ok & st_indirect);
      xwr_addr_r  <= st_ok ? st_addr : w13_r;
      xwr_data_r  <= wr_data;
    end
  end

  // Register thirteen: bus writes take priority over write-back.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w13_r <= `DSA_W13_RST;
    else if (wr_fire && awaddr_r == `DSA_W13_OFS)
    begin
      if (wstrb_r[0])
        w13_r[7:0] <= wdata_r[7:0];
      if (wstrb_r[1])
        w13_r[15:8] <= wdata_r[15:8];
    end
    else if (wb_ok && !st_indirect)
      w13_r <= wr_data;
    else if (wb_ok)
      w13_r <= w13_r + `DSA_W13_STEP;
  end

  // Barrel shifter: operand placement, amount limiting, one-cycle result.
  logic [39:0] sh_op;
  logic [79:0] sh_ext;
  logic signed [5:0] amt;
  logic        sh_right;
  always_comb
  begin
    amt = sh_amount;
    if (amt > `DSA_SH_MAX_R)
      amt = `DSA_SH_MAX_R;
    else if (amt < `DSA_SH_MAX_L)
      amt = `DSA_SH_MAX_L;
    sh_right = (amt > 6'sd0);
    case (dsa_pkg::dsa_shift_src_type'(sh_src))
      dsa_pkg::ss_acc_a: sh_op = acc_a_r;
      dsa_pkg::ss_acc_b: sh_op = acc_b_r;
      dsa_pkg::ss_xbus:
        if (sh_right)
          sh_op = {{8{sh_arith & xbus_in[15]}}, xbus_in, 16'h0000};
        else
          sh_op = {24'h000000, xbus_in};
      default: sh_op = '0;
    endcase
    sh_ext = {{40{sh_arith & sh_op[39]}}, sh_op};
    if (sh_right)
      sh_ext = sh_ext >> amt;
    else
      sh_ext = sh_ext << (-amt);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_res_r  <= '0;
      sh_word_r <= '0;
    end
    else if (sh_valid)
    begin
      sh_res_r  <= sh_ext[39:0];
      sh_word_r <= sh_right ? sh_ext[31:16] : sh_ext[15:0];
    end
  end

  // Write channel: take address and data in either order, then answer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `DSA_RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else
    begin
      if (awready_r && s_axi_awvalid)
      begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end
      if (wready_r && s_axi_wvalid)
      begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= known_reg(awaddr_r) ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Configuration register steers the saturation and rounding logic.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_r <= `DSA_CFG_RST;
    else if (wr_fire && awaddr_r == `DSA_CFG_OFS && wstrb_r[0])
      cfg_r <= wdata_r[5:0];
  end

  // Read channel: one outstanding read, answered the cycle after the address.
  logic [5:0] stat;
  assign stat = {sat_a_r | sat_b_r, ov_a_r | ov_b_r, sat_b_r, sat_a_r,
                 ov_b_r, ov_a_r};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `DSA_RESP_OKAY;
    end
    else if (arready_r && s_axi_arvalid)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= known_reg(s_axi_araddr) ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
      case (s_axi_araddr)
        `DSA_CFG_OFS:   rdata_r <= {26'h0, cfg_r};
        `DSA_STAT_OFS:  rdata_r <= {26'h0, stat};
        `DSA_W13_OFS:   rdata_r <= {16'h0000, w13_r};
        `DSA_ACCA_OFS:  rdata_r <= acc_a_r[31:0];
        `DSA_ACCB_OFS:  rdata_r <= acc_b_r[31:0];
        `DSA_GUARD_OFS: rdata_r <= {16'h0000, acc_b_r[39:32], acc_a_r[39:32]};
        default:        rdata_r <= '0;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Every output except the two OR-ed status_bits flags comes straight from a flip-flop.
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign xbus_wr_valid = xwr_valid_r;
  assign xbus_wr_addr  = xwr_addr_r;
  assign xbus_wr_data  = xwr_data_r;
  assign acc_a         = acc_a_r;
  assign acc_b         = acc_b_r;
  assign sh_result     = sh_res_r;
  assign sh_word       = sh_word_r;
  assign trap_request  = trap_r;
  assign status_bits   = {sat_a_r | sat_b_r, ov_a_r | ov_b_r, sat_b_r, sat_a_r,
                          ov_b_r, ov_a_r};

endmodule : dsa_accum_post
`default_nettype wire

// [testbench/dsa_accum_post_asserts.sv]
// Concurrent checks on the ports of the accumulator post-adder block.
`timescale 1ns/1ps
`default_nettype none
module dsa_accum_post_asserts (
  input wire logic              aclk,          // Core clock.
  input wire logic              aresetn,       // Synchronous reset, low.
  input wire logic              add_valid,     // Adder pass.
  input wire logic              add_target_b,  // Pass targets B.
  input wire logic [39:0]       add_result,    // Raw adder sum.
  input wire logic              add_ovf39,     // Bit 39 overflow.
  input wire logic [2:0]        st_kind,       // Store kind.
  input wire logic              st_indirect,   // Pointer write-back.
  input wire logic [15:0]       st_addr,       // Store address.
  input wire logic              sh_valid,      // Shift request.
  input wire logic [1:0]        sh_src,        // Shift source.
  input wire logic signed [5:0] sh_amount,     // Signed shift amount.
  input wire logic              sh_arith,      // Arithmetic right.
  input wire logic              xbus_wr_valid, // Data write strobe.
  input wire logic [15:0]       xbus_wr_addr,  // Data write address.
  input wire logic [39:0]       acc_a,         // Accumulator A.
  input wire logic [39:0]       sh_result,     // Shifter result.
  input wire logic              trap_request,  // Warning trap.
  input wire logic [5:0]        status_bits    // Status flags.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Shift checks skip adder cycles, since the accumulator may move under them.
  a_or_bits_match:
    assert property (status_bits[4] == (status_bits[0] | status_bits[1])
      && status_bits[5] == (status_bits[2] | status_bits[3])) else $error("combined flag wrong");
  a_ovf_sets_sat:
    assert property (add_valid && add_ovf39 && !add_target_b |=> status_bits[2])
      else $error("overflow did not set flag");
  a_sat_sticky:
    assert property (add_valid && status_bits[2] |=> status_bits[2]) else $error("flag dropped");
  a_guard_clear:
    assert property (add_valid && !add_target_b && (add_result[39:32] == 8'h00
      || add_result[39:32] == 8'hff) |=> !status_bits[0]) else $error("guard flag spurious");
  a_trap_cause:
    assert property (trap_request |-> $past(status_bits[3:2]) != 2'b00) else $error("trap uncaused");
  a_no_write:
    assert property (st_kind == 3'h0 || st_kind >= 3'h4 || (st_kind == 3'h3 && !st_indirect)
      |=> !xbus_wr_valid) else $error("unexpected data write");
  a_store_pulse:
    assert property (st_kind inside {3'h1, 3'h2} |=> xbus_wr_valid
      && xbus_wr_addr == $past(st_addr)) else $error("store write late or misplaced");
  a_shift_zero:
    assert property (sh_valid && sh_src == 2'd0 && sh_amount == 6'sd0 && !add_valid
      |=> sh_result == $past(acc_a)) else $error("zero shift changed operand");
  a_shift_right:
    assert property (sh_valid && sh_src == 2'd0 && sh_arith && sh_amount > 0 && sh_amount <= 15
      && !add_valid |=> $signed(sh_result) == ($signed($past(acc_a)) >>> $past(sh_amount)))
      else $error("right shift wrong");
  a_shift_left:
    assert property (sh_valid && sh_src == 2'd0 && sh_amount < 0 && sh_amount >= -16 && !add_valid
      |=> sh_result == ($past(acc_a) << (-$past(sh_amount)))) else $error("left shift wrong");
endmodule : dsa_accum_post_asserts
bind dsa_accum_post dsa_accum_post_asserts dsa_accum_post_asserts_inst (.*);
`default_nettype wire

// [testbench/dsa_xbus_mem.sv]
// Data space memory on the far side of the X bus write port.
`timescale 1ns/1ps
`default_nettype none
module dsa_xbus_mem (
  input  wire logic        aclk,          // Core clock.
  input  wire logic        xbus_wr_valid, // Write strobe.
  input  wire logic [15:0] xbus_wr_addr,  // Byte address.
  input  wire logic [15:0] xbus_wr_data,  // Word value.
  input  wire logic [15:0] rd_addr,       // Peek address.
  output logic      [15:0] rd_data        // Peek value.
);
  logic [15:0] mem_r [0:255];
  // Word store with no wait state; the low address bit is ignored for words.
  always_ff @(posedge aclk)
  begin
    if (xbus_wr_valid)
      mem_r[xbus_wr_addr[8:1]] <= xbus_wr_data;
  end
  // Unwritten words read unknown, so a lost write cannot pass as zero.
  assign rd_data = mem_r[rd_addr[8:1]];
endmodule : dsa_xbus_mem
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the accumulator post-adder block.
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module tb_top;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, add_valid, add_target_b, add_ovf39, st_acc_b, st_indirect;
  logic              sh_valid, sh_arith, xbus_wr_valid, trap_request;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, sh_src, resp;
  logic [39:0]       add_result, acc_a, acc_b, sh_result;
  logic [2:0]        st_kind;
  logic [15:0]       st_addr, xbus_in, xbus_wr_addr, xbus_wr_data, sh_word, rd_addr, rd_data;
  logic signed [5:0] sh_amount;
  logic [5:0]        status_bits;
  int                err_count, tests_run;
  // Fields: config, store kind, accumulator, expected data word.
  localparam logic [71:0] rtab [11] = '{
    {8'h00, 8'h01, 40'h0000128000, 16'h0012}, {8'h00, 8'h02, 40'h0000128000, 16'h0013},
    {8'h00, 8'h02, 40'h000012ffff, 16'h0013}, {8'h00, 8'h02, 40'h0000127fff, 16'h0012},
    {8'h10, 8'h02, 40'h0000128000, 16'h0012}, {8'h10, 8'h02, 40'h0000138000, 16'h0014},
    {8'h08, 8'h02, 40'h007fff8000, 16'h7fff}, {8'h08, 8'h02, 40'h007fff7fff, 16'h7fff},
    {8'h08, 8'h01, 40'hfe12340000, 16'h8000}, {8'h08, 8'h01, 40'h7f80000000, 16'h7fff},
    {8'h00, 8'h01, 40'h0012340000, 16'h1234}};

  dsa_accum_post dsa_accum_post_inst (.*);
  dsa_xbus_mem dsa_xbus_mem_inst (.*);

  // Free-running core clock, 40 ns period.
  always #20 aclk = ~aclk;

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // Bus write: address and data are held until each is taken, bready until bvalid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  // Core-side requests last one cycle; the 1 ns wait lets the edge's updates land.
  task automatic pass(input logic b, input logic [39:0] r, input logic o);
    @(posedge aclk);
    add_valid    <= 1'b1;
    add_target_b <= b;
    add_result   <= r;
    add_ovf39    <= o;
    @(posedge aclk);
    add_valid    <= 1'b0;
    #1;
  endtask : pass

  task automatic st(input logic [2:0] k, input logic b, input logic ind);
    @(posedge aclk);
    st_kind     <= k;
    st_acc_b    <= b;
    st_indirect <= ind;
    @(posedge aclk);
    st_kind     <= 3'h0;
    #1;
  endtask : st

  task automatic shc(input logic [1:0] s, input logic signed [5:0] n, input logic ar,
                     input logic [15:0] x, input logic [39:0] er, input logic [15:0] ew);
    @(posedge aclk);
    sh_valid  <= 1'b1;
    sh_src    <= s;
    sh_amount <= n;
    sh_arith  <= ar;
    xbus_in   <= x;
    @(posedge aclk);
    sh_valid  <= 1'b0;
    #1;
    chk(sh_result, er);
    chk(sh_word, ew);
  endtask : shc

  task automatic t_regs;
    rd(`DSA_CFG_OFS);
    chk(rdv, 32'h0);
    rd(8'h20);
    chk({resp, rdv}, {`DSA_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h1);
    chk(resp, `DSA_RESP_SLVERR);
  endtask : t_regs

  task automatic t_sat39;
    wr(`DSA_CFG_OFS, 32'h07);
    pass(1'b0, 40'h8000000001, 1'b1);
    chk(acc_a, `DSA_MAX39_POS);
    chk(status_bits, 6'h35);
    pass(1'b1, 40'h7ffffffffe, 1'b1);
    chk(acc_b, `DSA_MAX39_NEG);
    pass(1'b0, 40'h0000000010, 1'b0);
    chk(status_bits, 6'h3e);
    wr(`DSA_STAT_OFS, 32'h0c);
    rd(`DSA_STAT_OFS);
    chk(rdv, 32'h12);
  endtask : t_sat39

  task automatic t_sat31;
    wr(`DSA_CFG_OFS, 32'h01);
    // A clean pass through B drops the guard flag left by the previous scenario.
    pass(1'b1, 40'h0000000000, 1'b0);
    pass(1'b0, 40'h0180000000, 1'b0);
    chk(acc_a, `DSA_MAX31_POS);
    chk(status_bits, 6'h24);
    pass(1'b0, 40'hfe00000000, 1'b0);
    chk(acc_a, `DSA_MAX31_NEG);
    wr(`DSA_STAT_OFS, 32'h04);
  endtask : t_sat31

  task automatic t_catas;
    wr(`DSA_CFG_OFS, 32'h20);
    pass(1'b0, 40'h0100000000, 1'b0);
    chk(status_bits, 6'h11);
    pass(1'b0, 40'h8000000001, 1'b1);
    chk(acc_a, 40'h8000000001);
    chk(status_bits, 6'h35);
    @(posedge aclk);
    #1;
    chk(trap_request, 1'b1);
    wr(`DSA_STAT_OFS, 32'h04);
    repeat (2) @(posedge aclk);
    #1;
    chk(trap_request, 1'b0);
  endtask : t_catas

  task automatic t_round;
    for (int i = 0; i < 11; i++)
    begin
      wr(`DSA_CFG_OFS, {24'h0, rtab[i][71:64]});
      pass(1'b0, rtab[i][55:16], 1'b0);
      st(rtab[i][58:56], 1'b0, 1'b0);
      chk(xbus_wr_data, rtab[i][15:0]);
      chk(acc_a, rtab[i][55:16]);
    end
  endtask : t_round

  task automatic t_wb;
    wr(`DSA_CFG_OFS, 32'h00);
    pass(1'b1, 40'h0000348000, 1'b0);
    wr(`DSA_W13_OFS, 32'h0100);
    st(3'h3, 1'b1, 1'b1);
    chk({xbus_wr_valid, xbus_wr_addr, xbus_wr_data}, {1'b1, 32'h01000035});
    rd(`DSA_W13_OFS);
    chk(rdv, 32'h0102);
    rd_addr <= 16'h0100;
    st(3'h3, 1'b1, 1'b0);
    chk(rd_data, 16'h0035);
    chk(xbus_wr_valid, 1'b0);
    rd(`DSA_W13_OFS);
    chk(rdv, 32'h0035);
    for (int k = 4; k < 8; k++)
    begin
      st(3'(k), 1'b1, 1'b1);
      chk(xbus_wr_valid, 1'b0);
    end
  endtask : t_wb

  task automatic t_shift;
    pass(1'b0, 40'h80f0123456, 1'b0);
    shc(2'd2, 6'sd1, 1'b1, 16'h8001, 40'hffc0008000, 16'hc000);
    shc(2'd2, 6'sd1, 1'b0, 16'h8001, 40'h0040008000, 16'h4000);
    shc(2'd2, -6'sd4, 1'b1, 16'h8001, 40'h0000080010, 16'h0010);
    shc(2'd0, 6'sd4, 1'b1, 16'h0000, 40'hf80f012345, 16'h0f01);
    shc(2'd0, -6'sd16, 1'b0, 16'h0000, 40'h1234560000, 16'h0000);
    shc(2'd0, 6'sd0, 1'b0, 16'h0000, 40'h80f0123456, 16'h3456);
    shc(2'd1, 6'sd15, 1'b1, 16'h0000, 40'h0000000069, 16'h0000);
  endtask : t_shift

  // Main sequence: reset held four cycles, then each scenario in turn.
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, add_valid, add_target_b} = '0;
    {add_result, add_ovf39, st_kind, st_acc_b, st_indirect, sh_valid, sh_src} = '0;
    {sh_amount, sh_arith, xbus_in, rd_addr, err_count, tests_run} = '0;
    s_axi_wstrb = 4'hf;
    st_addr = 16'h0040;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_sat39;
    t_sat31;
    t_catas;
    t_round;
    t_wb;
    t_shift;
    finish_test;
  end

  // The run needs about two hundred cycles; ten thousand means a hang.
  initial
  begin
    #400000;
    err_count++;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
